// ===== design/oag_pkg.sv
/*
  oag_pkg: constants shared by the operand address generator.
  assumes a cpu core that presents instruction words and register values.
*/
package oag_pkg;
  localparam int ADDR_W = 20;
  localparam int WORD_W = 16;
  localparam int HI_W = 4;
  // source mode codes
  localparam logic [1:0] SRC_REG = 2'h0;
  localparam logic [1:0] SRC_IDX = 2'h1;
  localparam logic [1:0] SRC_IND = 2'h2;
  localparam logic [1:0] SRC_INC = 2'h3;
  localparam logic [3:0] PC_REG = 4'h0;
  // size codes from length-select and byte/word bits
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [1:0] SZ_BYTE = 2'h3;
  localparam logic [1:0] SZ_ADDR = 2'h1;
  // extension word field positions
  localparam int EXT_SRC_HI = 7;
  localparam int EXT_AL = 6;
  localparam int EXT_DST_HI = 0;
  localparam logic [19:0] INC_BYTE = 20'h00001;
  localparam logic [19:0] INC_WORD = 20'h00002;
  localparam logic [19:0] INC_ADDR = 20'h00004;
  localparam logic [19:0] NEXT_WORD = 20'h00002;
  typedef enum logic [2:0] {
    OAG_IDLE, OAG_SRC_LO, OAG_SRC_HI, OAG_DST_LO, OAG_DST_HI, OAG_DONE
  } oag_state_type;
endpackage : oag_pkg

// ===== design/oag_mem_if.sv
/*
  oag_mem_if: memory read request bundle between generator and fetch unit.
  assumes one outstanding read at a time.
*/
`timescale 1ns/10ps
`default_nettype none
interface oag_mem_if;
  logic req;
  logic [19:0] addr;
  logic ack;
  logic [15:0] rdata;
  modport gen (output req, output addr, input ack, input rdata);
  modport fetch (input req, input addr, output ack, output rdata);
endinterface : oag_mem_if
`default_nettype wire

// ===== design/oag_fetch.sv
/*
  oag_fetch: forwards operand word reads from the generator to the memory port.
  assumes memory answers req with ack carrying the read word.
*/
`timescale 1ns/10ps
`default_nettype none
module oag_fetch (
  oag_mem_if.fetch m,
  output logic mem_req,
  output logic [19:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata
);
  // pure pass-through adds no cycle of latency to the fetch
  assign mem_req = m.req;
  assign mem_addr = m.addr;
  assign m.ack = mem_ack;
  assign m.rdata = mem_rdata;
endmodule : oag_fetch
`default_nettype wire

// ===== design/oag_top.sv
/*
  oag_top: operand address generation for absolute, indirect, autoincrement
  and immediate modes, base and extended instructions.
  assumes the core holds the decoded fields stable from start until done.
*/
`timescale 1ns/10ps
`default_nettype none
// How it works
// - extended absolute address spans full 20 bits
// - address is ext high nibble plus next word
// - absolute allowed for source and destination
// - indirect uses register address, register unchanged
// - indirect decoded for source only
// - indirect forms take one to three words
// - autoincrement adds 1, 2 or 4
// - same register destination sees incremented value
// - immediate advances pc by two unless the constant generator serves it
// - base immediate is 16-bit next word
// - immediate length shrinks with constant generator
// - extended immediate is ext nibble plus word
// - extended immediate meets 20-bit destination
// - extension word gives index highs and length
module oag_top (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic is_ext,
  input wire logic [15:0] ext_word,
  input wire logic byte_mode,
  input wire logic [1:0] src_mode,
  input wire logic src_abs,
  input wire logic src_imm,
  input wire logic src_cg,
  input wire logic dst_abs,
  input wire logic [3:0] src_reg,
  input wire logic [3:0] dst_reg,
  input wire logic [19:0] src_reg_val,
  input wire logic [19:0] pc_val,
  input wire logic [15:0] src_word,
  input wire logic [15:0] dst_word,
  output logic mem_req,
  output logic [19:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  output logic done,
  output logic [19:0] src_addr,
  output logic [19:0] dst_addr,
  output logic [19:0] src_data,
  output logic wide_op,
  output logic reg_we,
  output logic [3:0] reg_sel,
  output logic [19:0] reg_wdata,
  output logic [19:0] dst_base_fwd,
  output logic [2:0] instr_words
);
  oag_mem_if m ();
  oag_fetch u_fetch (
    .m(m),
    .mem_req(mem_req),
    .mem_addr(mem_addr),
    .mem_ack(mem_ack),
    .mem_rdata(mem_rdata)
  );

  // join an upper nibble from the extension word to a 16-bit word
  function automatic logic [19:0] join20(input logic [3:0] hi, input logic [15:0] lo);
    return {hi, lo};
  endfunction : join20

  // size code to autoincrement step; the illegal code falls back to word
  function automatic logic [19:0] step_of(input logic [1:0] sz);
    unique case (sz)
      oag_pkg::SZ_BYTE: return oag_pkg::INC_BYTE;
      oag_pkg::SZ_ADDR: return oag_pkg::INC_ADDR;
      default: return oag_pkg::INC_WORD;
    endcase
  endfunction : step_of

  oag_pkg::oag_state_type st_q, st_d;
  // fw_q tracks the source register as the destination access must see it
  logic [19:0] sa_q, sa_d, da_q, da_d, sd_q, sd_d, fw_q, fw_d, rw_q, rw_d;
  logic [3:0] rs_q, rs_d;
  logic we_q, we_d, done_q, done_d, wide_q, wide_d;
  logic [2:0] nw_q, nw_d;
  logic al_bit;
  logic [1:0] sz;
  logic src_mem;

  // length select with byte bit picks 20-bit data
  assign al_bit = is_ext ? ext_word[oag_pkg::EXT_AL] : 1'b1;
  assign sz = {al_bit, byte_mode};
  assign src_mem = (src_mode == oag_pkg::SRC_IND) || (src_mode == oag_pkg::SRC_INC)
                   || src_abs;

  always_comb begin
    st_d = st_q;
    sa_d = sa_q;
    da_d = da_q;
    sd_d = sd_q;
    fw_d = fw_q;
    rw_d = rw_q;
    rs_d = rs_q;
    we_d = 1'b0;
    done_d = 1'b0;
    wide_d = wide_q;
    nw_d = nw_q;
    m.req = 1'b0;
    m.addr = '0;
    unique case (st_q)
      oag_pkg::OAG_IDLE: begin
        // fields are read here and again in later states; the core keeps them stable until done
        if (start) begin
          wide_d = (sz == oag_pkg::SZ_ADDR);
          fw_d = src_reg_val;
          sd_d = '0;
          // instruction word, optional extension word, one word per absolute address and per immediate not from the constant generator
          nw_d = 3'((is_ext ? 1 : 0) + 1 + ((src_imm && !src_cg) ? 1 : 0)
                    + (src_abs ? 1 : 0) + (dst_abs ? 1 : 0));
          if (src_imm) begin
            // immediate is autoincrement through the pc; the core already holds the word
            sd_d = is_ext ? join20(ext_word[oag_pkg::EXT_SRC_HI +: 4], src_word)
                          : {4'h0, src_word};
            sa_d = pc_val;
            if (!src_cg) begin
              we_d = 1'b1;
              rs_d = oag_pkg::PC_REG;
              rw_d = pc_val + oag_pkg::NEXT_WORD;
              fw_d = pc_val + oag_pkg::NEXT_WORD;
            end
            st_d = oag_pkg::OAG_DST_LO;
          end else if (src_abs) begin
            sa_d = is_ext ? join20(ext_word[oag_pkg::EXT_SRC_HI +: 4], src_word)
                          : {4'h0, src_word};
            st_d = oag_pkg::OAG_SRC_LO;
          end else if (src_mem) begin
            sa_d = src_reg_val;
            st_d = oag_pkg::OAG_SRC_LO;
          end else begin
            st_d = oag_pkg::OAG_DST_LO;
          end
        end
      end
      oag_pkg::OAG_SRC_LO: begin
        m.req = 1'b1;
        // request and address stay up through every stall until the answer
        m.addr = sa_q;
        if (m.ack) begin
          sd_d = {4'h0, m.rdata};
          st_d = wide_q ? oag_pkg::OAG_SRC_HI : oag_pkg::OAG_DST_LO;
          if (!wide_q && src_mode == oag_pkg::SRC_INC && !src_abs) begin
            we_d = 1'b1;
            rs_d = src_reg;
            rw_d = sa_q + step_of(sz);
            fw_d = sa_q + step_of(sz);
          end
        end
      end
      oag_pkg::OAG_SRC_HI: begin
        m.req = 1'b1;
        m.addr = sa_q + oag_pkg::NEXT_WORD;
        if (m.ack) begin
          // only the low nibble of the upper word carries address-word data
          sd_d = {m.rdata[3:0], sd_q[15:0]};
          st_d = oag_pkg::OAG_DST_LO;
          if (src_mode == oag_pkg::SRC_INC && !src_abs) begin
            we_d = 1'b1;
            rs_d = src_reg;
            rw_d = sa_q + step_of(sz);
            fw_d = sa_q + step_of(sz);
          end
        end
      end
      oag_pkg::OAG_DST_LO: begin
        // destination base after the source fetch side effect
        if (dst_abs) begin
          da_d = is_ext ? join20(ext_word[oag_pkg::EXT_DST_HI +: 4], dst_word)
                        : {4'h0, dst_word};
        end else begin
          da_d = (dst_reg == src_reg) ? fw_q : '0;
        end
        st_d = oag_pkg::OAG_DONE;
      end
      oag_pkg::OAG_DONE: begin
        // one-cycle pulse; the data outputs hold until the next start
        done_d = 1'b1;
        st_d = oag_pkg::OAG_IDLE;
      end
      default: st_d = oag_pkg::OAG_IDLE;
    endcase
  end

  // synchronous reset, in step with the core's own registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_q <= oag_pkg::OAG_IDLE;
      sa_q <= '0;
      da_q <= '0;
      sd_q <= '0;
      fw_q <= '0;
      rw_q <= '0;
      rs_q <= '0;
      we_q <= 1'b0;
      done_q <= 1'b0;
      wide_q <= 1'b0;
      nw_q <= '0;
    end else begin
      st_q <= st_d;
      sa_q <= sa_d;
      da_q <= da_d;
      sd_q <= sd_d;
      fw_q <= fw_d;
      rw_q <= rw_d;
      rs_q <= rs_d;
      we_q <= we_d;
      done_q <= done_d;
      wide_q <= wide_d;
      nw_q <= nw_d;
    end
  end

  assign done = done_q;
  assign src_addr = sa_q;
  assign dst_addr = da_q;
  assign src_data = sd_q;
  assign wide_op = wide_q;
  assign reg_we = we_q;
  assign reg_sel = rs_q;
  assign reg_wdata = rw_q;
  assign dst_base_fwd = fw_q;
  assign instr_words = nw_q;

  // checks on what the generator drives; step of the size held while busy
  logic [19:0] inc_step;
  assign inc_step = step_of(sz);

  // one-word source read that ends an autoincrement fetch
  sequence s_inc_lo;
    st_q == oag_pkg::OAG_SRC_LO && m.ack && !wide_q
      && src_mode == oag_pkg::SRC_INC && !src_abs;
  endsequence

  // upper-word read that ends an address-word autoincrement fetch
  sequence s_inc_hi;
    st_q == oag_pkg::OAG_SRC_HI && m.ack && src_mode == oag_pkg::SRC_INC && !src_abs;
  endsequence

  // lower half of an address-word operand answered
  sequence s_wide_lo;
    st_q == oag_pkg::OAG_SRC_LO && m.ack && wide_q;
  endsequence

  // extended instruction with an absolute source taken
  sequence s_abs_start;
    st_q == oag_pkg::OAG_IDLE && start && is_ext && src_abs && !src_imm;
  endsequence

  a_pc_step: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_q == oag_pkg::OAG_IDLE && start && src_imm && !src_cg) |=>
      (reg_we && reg_wdata == $past(pc_val) + 20'h00002))
    else $error("pc not advanced by two");
  a_cg_keep_pc: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_q == oag_pkg::OAG_IDLE && start && src_imm && src_cg) |=> !reg_we)
    else $error("pc written although the constant generator served");

  a_ind_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_q == oag_pkg::OAG_SRC_LO && m.ack && src_mode == oag_pkg::SRC_IND) |=> !reg_we)
    else $error("indirect register modified");
  a_req_addr: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_q == oag_pkg::OAG_SRC_LO) |-> (mem_req && mem_addr == src_addr))
    else $error("source read not at the source address");

  a_inc_lo_step: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_inc_lo |=> (reg_we && reg_sel == $past(src_reg) && reg_wdata == $past(sa_q + inc_step)))
    else $error("autoincrement step wrong after one-word fetch");
  a_inc_hi_step: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_inc_hi |=> (reg_we && reg_sel == $past(src_reg) && reg_wdata == $past(sa_q + inc_step)))
    else $error("autoincrement step wrong after address-word fetch");
  a_wide_pair: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_wide_lo |=> (st_q == oag_pkg::OAG_SRC_HI && mem_req
                   && mem_addr == $past(mem_addr) + 20'h00002))
    else $error("upper word of address-word operand not read next");

  a_abs_src: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_abs_start |=>
      (src_addr == {$past(ext_word[oag_pkg::EXT_SRC_HI +: 4]), $past(src_word)}))
    else $error("extended absolute source address wrong");
  a_abs_dst: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_q == oag_pkg::OAG_DST_LO && is_ext && dst_abs) |=>
      (dst_addr == {$past(ext_word[oag_pkg::EXT_DST_HI +: 4]), $past(dst_word)}))
    else $error("extended absolute destination address wrong");

  a_words_range: assert property (@(posedge core_clk) disable iff (!rst_n)
    done |-> (instr_words >= 3'h1 && instr_words <= 3'h4))
    else $error("instruction length outside one to four words");
  a_wide_imm: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_q == oag_pkg::OAG_IDLE && start && is_ext && src_imm && sz == oag_pkg::SZ_ADDR) |=> wide_op)
    else $error("extended immediate not marked as 20-bit operation");
  a_done_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
    done |=> !done)
    else $error("done longer than one cycle");
endmodule : oag_top
`default_nettype wire

// ===== tb/oag_top_tb.sv
/*
  oag_top_tb: random and corner operand fetches through oag_top.
  assumes oag_pkg and oag_top compiled first; memory is answered here.
*/
`timescale 1ns/10ps
`default_nettype none
module oag_top_tb;
  logic core_clk, rst_n, start, is_ext, byte_mode, src_abs, src_imm, src_cg, dst_abs;
  logic mem_req, mem_ack, done, wide_op, reg_we;
  logic [1:0] src_mode, sz;
  logic [2:0] instr_words;
  logic [3:0] src_reg, dst_reg, reg_sel, we_sel;
  logic [15:0] ext_word, src_word, dst_word, mem_rdata, sw, dw, ew;
  logic [19:0] src_reg_val, pc_val, mem_addr, src_addr, dst_addr, src_data, reg_wdata;
  logic [19:0] dst_base_fwd, rv, pc, we_val;
  logic [19:0] aq[$];
  int seed, errors, compares, we_n, tn;
  oag_top u_oag_top (.core_clk, .rst_n, .start, .is_ext, .ext_word, .byte_mode, .src_mode,
    .src_abs, .src_imm, .src_cg, .dst_abs, .src_reg, .dst_reg, .src_reg_val, .pc_val,
    .src_word, .dst_word, .mem_req, .mem_addr, .mem_ack, .mem_rdata, .done, .src_addr,
    .dst_addr, .src_data, .wide_op, .reg_we, .reg_sel, .reg_wdata, .dst_base_fwd,
    .instr_words);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  function automatic logic [15:0] memf(input logic [19:0] a);
    return a[15:0] ^ {a[19:16], 12'h5a5};
  endfunction : memf
  // address-word operand: low word at a, upper nibble in the word at a+2
  function automatic logic [19:0] wordf(input logic [19:0] a);
    logic [15:0] h;
    h = memf(a + 20'h00002);
    return {h[3:0], memf(a)};
  endfunction : wordf
  function automatic logic [19:0] incv(input logic [1:0] s);
    return (s == 2'h0) ? oag_pkg::INC_BYTE : (s == 2'h1) ? oag_pkg::INC_WORD : oag_pkg::INC_ADDR;
  endfunction : incv
  // random stalls; a released data bus shows a changing pattern, not the last word
  always @(negedge core_clk) begin
    if (mem_req === 1'b1 && mem_ack !== 1'b1 && $random(seed) % 2 == 0) begin
      mem_ack <= 1'b1;
      mem_rdata <= memf(mem_addr);
      aq.push_back(mem_addr);
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end
  end
  always @(negedge core_clk) begin
    if (reg_we === 1'b1) begin
      we_n++;
      we_sel = reg_sel;
      we_val = reg_wdata;
    end
  end
  task results;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results
  task chk(input logic [19:0] seen, input logic [19:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // sz: 0 byte, 1 word, 2 address-word (length-select low with byte/word high)
  task go(input logic x, input logic [1:0] s, input logic [1:0] md, input logic ab, input logic im);
    int n;
    pc = 20'($random(seed));
    rv = im ? pc : 20'($random(seed));
    sw = 16'($random(seed));
    dw = 16'($random(seed));
    ew = 16'($random(seed));
    if (tn == 0) begin
      ew = 16'hffff;
      sw = 16'hffff;
    end
    ew[6] = (s != 2'h2);
    is_ext = x;
    byte_mode = (s != 2'h1);
    src_mode = md;
    src_abs = ab;
    dst_abs = ab;
    src_imm = im;
    src_reg = im ? oag_pkg::PC_REG : 4'h5;
    dst_reg = src_reg;
    src_reg_val = rv;
    pc_val = pc;
    src_word = sw;
    dst_word = dw;
    ext_word = ew;
    we_n = 0;
    aq.delete();
    start = 1'b1;
    @(negedge core_clk);
    start = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 60) begin
      @(negedge core_clk);
      n++;
    end
    if (done !== 1'b1) begin
      errors++;
      results();
    end
    tn++;
    $display("test %0d ended", tn);
  endtask : go
  initial begin
    seed = 81597;
    {start, is_ext, byte_mode, src_abs, src_imm, src_cg, dst_abs, mem_ack} = '0;
    {src_mode, src_reg, dst_reg, src_reg_val, pc_val} = '0;
    {ext_word, src_word, dst_word, mem_rdata} = '0;
    rst_n = 1'b0;
    repeat (3) @(negedge core_clk);
    rst_n = 1'b1;
    for (int k = 0; k < 3; k++) begin
      go(1'b1, 2'h1, oag_pkg::SRC_IDX, 1'b1, 1'b0);
      chk(src_addr, {ew[10:7], sw});
      chk(aq[0], {ew[10:7], sw});
      chk(dst_addr, {ew[3:0], dw});
      chk(20'(instr_words), 20'h00004);
    end
    for (int k = 0; k < 6; k++) begin
      sz = 2'(k % 3);
      go(1'b1, sz, oag_pkg::SRC_INC, 1'b0, 1'b0);
      chk(20'(we_n), 20'h00001);
      chk(we_val, rv + incv(sz));
      chk({16'h0, we_sel}, 20'h00005);
      chk(aq[0], rv);
      chk(dst_base_fwd, rv + incv(sz));
      chk(dst_addr, rv + incv(sz));
      chk(20'(instr_words), 20'h00002);
      if (sz == 2'h2) begin
        chk(aq[1], rv + 20'h00002);
        chk(src_data, wordf(rv));
        chk({19'h0, wide_op}, 20'h00001);
      end else begin
        chk(src_data, {4'h0, memf(rv)});
        chk({19'h0, wide_op}, 20'h00000);
      end
    end
    for (int k = 0; k < 4; k++) begin
      go(k[0], 2'h1, oag_pkg::SRC_IND, 1'b0, 1'b0);
      chk(20'(we_n), 20'h00000);
      chk(src_addr, rv);
      chk(aq[0], rv);
      chk(dst_addr, rv);
      chk(20'(instr_words), k[0] ? 20'h00002 : 20'h00001);
    end
    for (int k = 0; k < 6; k++) begin
      sz = 2'(k % 3);
      go(k < 3, sz, oag_pkg::SRC_INC, 1'b0, 1'b1);
      chk(we_val, pc + oag_pkg::NEXT_WORD);
      chk({16'h0, we_sel}, {16'h0, oag_pkg::PC_REG});
      chk(20'(we_n), 20'h00001);
      chk(dst_base_fwd, pc + oag_pkg::NEXT_WORD);
      chk(20'(instr_words), (k < 3) ? 20'h00003 : 20'h00002);
      if (k < 3 && sz == 2'h2) begin
        chk(src_data, {ew[10:7], sw});
        chk({19'h0, wide_op}, 20'h00001);
      end
      if (k >= 3 && sz == 2'h1)
        chk(src_data, {4'h0, sw});
    end
    // constant generator serves the immediate: no word fetched, pc untouched
    src_cg = 1'b1;
    for (int k = 0; k < 2; k++) begin
      go(k[0], 2'h1, oag_pkg::SRC_INC, 1'b0, 1'b1);
      chk(20'(we_n), 20'h00000);
      chk(20'(instr_words), k[0] ? 20'h00002 : 20'h00001);
    end
    results();
  end
endmodule : oag_top_tb
`default_nettype wire
